// *** fcsr_regs.sv ***
// How it works
// [R1] Index register holds parameter word index
// [R2] Protection status register ignores all writes
// [R3] Bit 7 shows protection override active
// [R4] Changing wait-state field clears acknowledge bit
// [R5] Reads use old timing until acknowledge sets
// [R6] Software waits for acknowledge before clock change
// [R7] Config bits writable except erase-all status
// [R8] Command-done interrupt gated by its enable
// [R9] Erase-all status sets when sequence starts
// [R10] Erase, verify, program security, then unsecure
// [R11] Erase-all status clears when sequence ends
// [R12] Suppress bit hides single-bit fault reports
// [R13] Wait field: 00 maximum, 11 disabled
// [R14] Wait field resets to maximum wait setting
// [R15] Wait field frozen while a command runs
// [R16] Force-double bit flags every array read
// [R17] Force-single bit flags reads, may interrupt
// [R18] At most one wait cycle per read
// [R19] Writing one to done flag launches command
// [R20] Reserved wait values read back, act maximum
// [R21] Security field value 10 means unsecured
// [R22] Acknowledge clears only on real wait change
module fcsr_regs #(
    parameter logic [15:0] CMD_CYCLES = fcsr_pkg::CMD_CYCLES_DEF,
    parameter logic [15:0] STEP_CYCLES = fcsr_pkg::STEP_CYCLES_DEF
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [fcsr_pkg::ADDR_W-1:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire fcsr_pkg::fcsr_rd_t ARRAY_RD_I,
    output logic ARRAY_RD_DONE_O,
    input wire logic PROT_OVERRIDE_I,
    input wire logic ERASE_ALL_REQ_I,
    input wire logic BACKDOOR_UNSECURE_I,
    input wire logic CMD_VIOLATION_I,
    output logic CMD_DONE_IRQ_O,
    output logic SINGLE_FAULT_IRQ_O,
    output logic [1:0] SECURITY_STATE_O
);
    import fcsr_pkg::*;

    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [PARAM_IDX_W-1:0] pidx_q, pidx_d;
    logic irq_en_q, irq_en_d;
    logic ign_q, ign_d;
    logic [1:0] ws_q, ws_d;
    logic fdf_q, fdf_d;
    logic fsf_q, fsf_d;
    logic ersa_q, ersa_d;
    logic ovr_q, ovr_d;
    logic wsack_q, wsack_d;
    logic ws_eff_q, ws_eff_d;
    logic sgl_ie_q, sgl_ie_d;
    logic sgl_flag_q, sgl_flag_d;
    logic dbl_flag_q, dbl_flag_d;
    logic done_q, done_d;
    logic [1:0] sec_q, sec_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    fcsr_ers_t ers_q, ers_d;
    logic rd_busy_q, rd_busy_d;
    logic rd_wait_q, rd_wait_d;
    logic rd_done_q, rd_done_d;
    logic bus_req, bus_wr;
    logic [3:0] idx;
    logic [7:0] wbyte, rbyte;
    logic ws_change, cnt_zero, rd_start, rd_finish;

    assign idx = ADR_I[5:2];
    assign bus_req = CYC_I & STB_I;
    assign bus_wr = bus_req & WE_I & ack_q & SEL_I[0];
    assign wbyte = DAT_I[7:0];
    assign cnt_zero = (cnt_q == '0);
    assign ws_change = bus_wr && idx == IDX_CONFIG && done_q
        && wbyte[CFG_WS_HI:CFG_WS_LO] != ws_q;
    assign rd_start = ARRAY_RD_I.req & ~rd_busy_q & ~rd_done_q;
    assign rd_finish = rd_busy_q & ~rd_wait_q;

    // Read mux; unmapped indexes and unassigned bits read zero
    always_comb begin
        rbyte = 8'h00;
        unique case (idx)
            IDX_SECURITY: rbyte[1:0] = sec_q; // [R21]
            IDX_CMD_INDEX: rbyte[PARAM_IDX_W-1:0] = pidx_q; // [R1]
            IDX_PROT_STAT: begin // [R2]
                rbyte[PST_OVR_BIT] = ovr_q; // [R3]
                rbyte[PST_ACK_BIT] = wsack_q;
            end
            IDX_CONFIG: begin
                rbyte[CFG_IRQ_BIT] = irq_en_q; // [R7]
                rbyte[CFG_ERSA_BIT] = ersa_q;
                rbyte[CFG_IGN_BIT] = ign_q;
                rbyte[CFG_WS_HI:CFG_WS_LO] = ws_q; // [R20]
                rbyte[CFG_FDF_BIT] = fdf_q;
                rbyte[CFG_FSF_BIT] = fsf_q;
            end
            IDX_ERR_CFG: rbyte[ECF_SGL_IE_BIT] = sgl_ie_q;
            IDX_CMD_STAT: begin
                rbyte[CST_DONE_BIT] = done_q;
                rbyte[CST_BUSY_BIT] = ~done_q;
            end
            IDX_ERR_STAT: begin
                rbyte[EST_DBL_BIT] = dbl_flag_q;
                rbyte[EST_SGL_BIT] = sgl_flag_q;
            end
            default: rbyte = 8'h00;
        endcase
    end

    always_comb begin
        ack_d = bus_req & ~ack_q;
        dat_d = (bus_req & ~ack_q & ~WE_I) ? {24'h000000, rbyte} : 32'h00000000;
        pidx_d = pidx_q;
        irq_en_d = irq_en_q;
        ign_d = ign_q;
        ws_d = ws_q;
        fdf_d = fdf_q;
        fsf_d = fsf_q;
        sgl_ie_d = sgl_ie_q;
        ovr_d = PROT_OVERRIDE_I; // [R3]
        if (bus_wr && idx == IDX_CMD_INDEX) begin
            pidx_d = wbyte[PARAM_IDX_W-1:0]; // [R1]
        end
        if (bus_wr && idx == IDX_CONFIG) begin
            irq_en_d = wbyte[CFG_IRQ_BIT]; // [R7]
            ign_d = wbyte[CFG_IGN_BIT];
            fdf_d = wbyte[CFG_FDF_BIT]; // [R16]
            fsf_d = wbyte[CFG_FSF_BIT]; // [R17]
            if (done_q) begin
                ws_d = wbyte[CFG_WS_HI:CFG_WS_LO]; // [R15]
            end
        end
        if (bus_wr && idx == IDX_ERR_CFG) begin
            sgl_ie_d = wbyte[ECF_SGL_IE_BIT];
        end
    end

    // Timing switch happens only between array reads, so a read never mixes settings
    always_comb begin
        ws_eff_d = ws_eff_q;
        wsack_d = wsack_q;
        if (ws_change) begin
            wsack_d = 1'b0; // [R4] [R22]
        end else if (!wsack_q && !rd_busy_q && !rd_start) begin
            ws_eff_d = (ws_q != WS_OFF); // [R13] [R20]
            wsack_d = 1'b1; // [R5]
        end
    end

    // Array read timing and fault flags
    always_comb begin
        rd_busy_d = rd_busy_q;
        rd_wait_d = rd_wait_q;
        rd_done_d = 1'b0;
        sgl_flag_d = sgl_flag_q;
        dbl_flag_d = dbl_flag_q;
        if (rd_start) begin
            rd_busy_d = 1'b1;
            rd_wait_d = ws_eff_q; // [R18]
        end else if (rd_busy_q && rd_wait_q) begin
            rd_wait_d = 1'b0;
        end else if (rd_finish) begin
            rd_busy_d = 1'b0;
            rd_done_d = 1'b1;
        end
        if (bus_wr && idx == IDX_ERR_STAT) begin
            if (wbyte[EST_SGL_BIT]) begin
                sgl_flag_d = 1'b0;
            end
            if (wbyte[EST_DBL_BIT]) begin
                dbl_flag_d = 1'b0;
            end
        end
        if (rd_finish && (ARRAY_RD_I.single_err || fsf_q) && !ign_q) begin
            sgl_flag_d = 1'b1; // [R12] [R17]
        end
        if (rd_finish && (ARRAY_RD_I.double_err || fdf_q)) begin
            dbl_flag_d = 1'b1; // [R16]
        end
    end

    // Command engine and erase-all sequence
    always_comb begin
        done_d = done_q;
        cnt_d = cnt_q;
        ers_d = ers_q;
        ersa_d = ersa_q;
        sec_d = sec_q;
        if (BACKDOOR_UNSECURE_I) begin
            sec_d = SEC_UNSECURED; // [R21]
        end
        unique case (ers_q)
            ES_IDLE: begin
                if (done_q && ERASE_ALL_REQ_I) begin
                    ers_d = ES_ERASE; // [R9]
                    ersa_d = 1'b1;
                    done_d = 1'b0;
                    cnt_d = STEP_CYCLES;
                end else if (done_q && bus_wr && idx == IDX_CMD_STAT && wbyte[CST_DONE_BIT]) begin
                    done_d = 1'b0; // [R19]
                    cnt_d = CMD_CYCLES;
                end else if (!done_q) begin
                    cnt_d = cnt_q - 16'h0001;
                    if (cnt_zero || CMD_VIOLATION_I) begin
                        done_d = 1'b1; // [R19]
                        cnt_d = '0;
                    end
                end
            end
            ES_ERASE, ES_VERIFY, ES_PROG: begin
                cnt_d = cnt_q - 16'h0001;
                if (cnt_zero) begin
                    cnt_d = STEP_CYCLES;
                    ers_d = (ers_q == ES_ERASE) ? ES_VERIFY :
                            (ers_q == ES_VERIFY) ? ES_PROG : ES_UNSEC; // [R10]
                end
            end
            ES_UNSEC: begin
                sec_d = SEC_UNSECURED; // [R10] [R21]
                ersa_d = 1'b0; // [R11]
                done_d = 1'b1;
                cnt_d = '0;
                ers_d = ES_IDLE;
            end
            default: begin
                ers_d = ES_IDLE;
                ersa_d = 1'b0;
                done_d = 1'b1;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
            pidx_q <= IDX_RESET;
            irq_en_q <= 1'b0;
            ign_q <= 1'b0;
            ws_q <= WS_MAX; // [R14]
            fdf_q <= 1'b0;
            fsf_q <= 1'b0;
            sgl_ie_q <= 1'b0;
            ovr_q <= 1'b0;
            ws_eff_q <= 1'b1;
            wsack_q <= 1'b1;
            rd_busy_q <= 1'b0;
            rd_wait_q <= 1'b0;
            rd_done_q <= 1'b0;
            sgl_flag_q <= 1'b0;
            dbl_flag_q <= 1'b0;
            done_q <= 1'b1;
            cnt_q <= '0;
            ers_q <= ES_IDLE;
            ersa_q <= 1'b0;
            sec_q <= SEC_RESET;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            pidx_q <= pidx_d;
            irq_en_q <= irq_en_d;
            ign_q <= ign_d;
            ws_q <= ws_d;
            fdf_q <= fdf_d;
            fsf_q <= fsf_d;
            sgl_ie_q <= sgl_ie_d;
            ovr_q <= ovr_d;
            ws_eff_q <= ws_eff_d;
            wsack_q <= wsack_d;
            rd_busy_q <= rd_busy_d;
            rd_wait_q <= rd_wait_d;
            rd_done_q <= rd_done_d;
            sgl_flag_q <= sgl_flag_d;
            dbl_flag_q <= dbl_flag_d;
            done_q <= done_d;
            cnt_q <= cnt_d;
            ers_q <= ers_d;
            ersa_q <= ersa_d;
            sec_q <= sec_d;
        end
    end

    assign ACK_O = ack_q;
    assign DAT_O = dat_q;
    assign ARRAY_RD_DONE_O = rd_done_q;
    assign CMD_DONE_IRQ_O = irq_en_q & done_q; // [R8]
    assign SINGLE_FAULT_IRQ_O = sgl_ie_q & sgl_flag_q; // [R17]
    assign SECURITY_STATE_O = sec_q;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence ers_steps_s;
        ers_q == ES_ERASE [*1] ##[1:300] ers_q == ES_VERIFY ##[1:300] ers_q == ES_PROG;
    endsequence
    sequence ers_end_s;
        ers_q == ES_UNSEC ##1 (sec_q == SEC_UNSECURED && !ersa_q && done_q);
    endsequence

    idx_write_a: assert property (bus_wr && idx == IDX_CMD_INDEX |=> pidx_q == $past(wbyte[2:0])) // [R1]
        else $error("index register did not take written value");
    prot_ro_a: assert property (bus_wr && idx == IDX_PROT_STAT && !ws_change |=> $stable(wsack_q) || wsack_q) // [R2]
        else $error("protection status changed by a write");
    ovr_mirror_a: assert property (ovr_q == $past(PROT_OVERRIDE_I)) // [R3]
        else $error("override bit does not follow override state");
    ack_clear_a: assert property (ws_change |=> !wsack_q) // [R4]
        else $error("acknowledge not cleared on wait-state change");
    ack_hold_a: assert property (!wsack_q && rd_busy_q |=> $stable(ws_eff_q)) // [R5]
        else $error("read timing switched during a read");
    ack_only_diff_a: assert property (bus_wr && idx == IDX_CONFIG && wbyte[3:2] == ws_q && wsack_q |=> wsack_q) // [R22]
        else $error("acknowledge cleared without a change");
    irq_cmd_a: assert property (CMD_DONE_IRQ_O == (irq_en_q && done_q)) // [R8]
        else $error("command interrupt mismatch");
    ers_start_a: assert property (ers_q == ES_IDLE && done_q && ERASE_ALL_REQ_I |=> (ersa_q and ers_steps_s)) // [R9] [R10]
        else $error("erase-all sequence did not start in order");
    ers_finish_a: assert property (ers_q == ES_PROG && cnt_zero |=> ers_end_s) // [R11] [R10]
        else $error("erase-all did not finish cleanly");
    ws_frozen_a: assert property (!done_q |=> $stable(ws_q)) // [R15]
        else $error("wait field changed while command ran");
    ws_reserved_a: assert property (!wsack_q && !rd_busy_q && !rd_start && !ws_change |=> ws_eff_q == ($past(ws_q) != 2'h3)) // [R13] [R20]
        else $error("wait decode wrong");
    read_wait_a: assert property (rd_start |-> if (ws_eff_q) ##3 rd_done_q else ##2 rd_done_q) // [R18]
        else $error("array read wait count wrong");
    dbl_force_a: assert property (rd_finish && fdf_q |=> dbl_flag_q) // [R16]
        else $error("forced double fault not flagged");
    sgl_force_a: assert property (rd_finish && fsf_q && !ign_q && sgl_ie_q |=> SINGLE_FAULT_IRQ_O) // [R17]
        else $error("forced single fault did not interrupt");
    suppress_a: assert property (ign_q && !sgl_flag_q && !bus_wr |=> !sgl_flag_q) // [R12]
        else $error("suppressed single fault was reported");
    launch_a: assert property (ers_q == ES_IDLE && done_q && !ERASE_ALL_REQ_I && bus_wr && idx == IDX_CMD_STAT
        && wbyte[7] |=> !done_q) // [R19]
        else $error("command not launched");

endmodule : fcsr_regs

// *** fcsr_pkg.sv ***
package fcsr_pkg;

    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned ADDR_W = 6;

    // Register indexes; the byte address is four times the index
    localparam logic [3:0] IDX_SECURITY = 4'h1;
    localparam logic [3:0] IDX_CMD_INDEX = 4'h2;
    localparam logic [3:0] IDX_PROT_STAT = 4'h3;
    localparam logic [3:0] IDX_CONFIG = 4'h4;
    localparam logic [3:0] IDX_ERR_CFG = 4'h5;
    localparam logic [3:0] IDX_CMD_STAT = 4'h6;
    localparam logic [3:0] IDX_ERR_STAT = 4'h7;

    localparam int unsigned PARAM_IDX_W = 3;
    localparam int unsigned CFG_IRQ_BIT = 7;
    localparam int unsigned CFG_ERSA_BIT = 5;
    localparam int unsigned CFG_IGN_BIT = 4;
    localparam int unsigned CFG_WS_HI = 3;
    localparam int unsigned CFG_WS_LO = 2;
    localparam int unsigned CFG_FDF_BIT = 1;
    localparam int unsigned CFG_FSF_BIT = 0;
    localparam int unsigned PST_OVR_BIT = 7;
    localparam int unsigned PST_ACK_BIT = 0;
    localparam int unsigned CST_DONE_BIT = 7;
    localparam int unsigned CST_BUSY_BIT = 3;
    localparam int unsigned EST_DBL_BIT = 1;
    localparam int unsigned EST_SGL_BIT = 0;
    localparam int unsigned ECF_SGL_IE_BIT = 0;

    localparam logic [1:0] WS_MAX = 2'h0;
    localparam logic [1:0] WS_OFF = 2'h3;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [1:0] SEC_RESET = 2'h3;
    localparam logic [PARAM_IDX_W-1:0] IDX_RESET = 3'h0;

    localparam int unsigned CNT_W = 16;
    localparam logic [15:0] CMD_CYCLES_DEF = 16'h0010;
    localparam logic [15:0] STEP_CYCLES_DEF = 16'h0008;

    typedef struct packed {
        logic req;
        logic single_err;
        logic double_err;
    } fcsr_rd_t;

    typedef enum logic [2:0] {
        ES_IDLE = 3'h0,
        ES_ERASE = 3'h1,
        ES_VERIFY = 3'h3,
        ES_PROG = 3'h2,
        ES_UNSEC = 3'h6
    } fcsr_ers_t;

endpackage : fcsr_pkg

// *** fcsr_regs_tb.sv ***
module fcsr_regs_tb import fcsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic ack;
    fcsr_rd_t rd;
    logic rd_done;
    logic ovr;
    logic ers_req;
    logic bkdr;
    logic viol;
    logic cmd_irq;
    logic sgl_irq;
    logic [1:0] sec;
    logic [31:0] q;
    logic [7:0] v;
    int bad_count;
    int comparisons;

    fcsr_regs #(.CMD_CYCLES(16'h0010), .STEP_CYCLES(16'h0004)) fcsr_regs_inst (
        .CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .ARRAY_RD_I(rd), .ARRAY_RD_DONE_O(rd_done),
        .PROT_OVERRIDE_I(ovr), .ERASE_ALL_REQ_I(ers_req), .BACKDOOR_UNSECURE_I(bkdr),
        .CMD_VIOLATION_I(viol), .CMD_DONE_IRQ_O(cmd_irq), .SINGLE_FAULT_IRQ_O(sgl_irq),
        .SECURITY_STATE_O(sec)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: value 0x%0h, expected 0x%0h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_num(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            bad_count++;
            $display("Error at %0t: read latency %0d, expected %0d", $time, got, exp);
        end
    endtask : chk_num

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            $display("Error at %0t: bus answer missing", $time);
        end
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00);
        chk_reg(q, exp);
    endtask : rd_chk

    // Latency counted in falling edges from the edge that raises req
    task automatic arr(input logic se, input logic de, input int exp_lat);
        int n;
        n = 0;
        @(posedge clk);
        rd <= '{req: 1'b1, single_err: se, double_err: de};
        do begin
            @(negedge clk);
            n++;
        end while (rd_done !== 1'b1 && n < 10);
        chk_num(n, exp_lat);
        @(posedge clk);
        rd <= '0;
    endtask : arr

    task automatic wait_done;
        int n;
        n = 0;
        do begin
            wb(1'b0, 6'h18, 8'h00);
            n++;
        end while (q[7] !== 1'b1 && n < 100);
        if (n >= 100) begin
            bad_count++;
            $display("Error at %0t: command never completed", $time);
        end
    endtask : wait_done

    initial begin
        #(40 * 10000);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        {cyc, stb, we, ovr, ers_req, bkdr, viol} = '0;
        adr = '0;
        sel = 4'hF;
        dat_w = '0;
        rd = '0;
        rst_n = 1'b0;
        bad_count = 0;
        comparisons = 0;
        void'($urandom(75673));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg({30'h0, sec}, {30'h0, SEC_RESET});
        rd_chk(6'h10, 32'h00);
        rd_chk(6'h0C, 32'h01);
        arr(1'b0, 1'b0, 4);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            wr(6'h08, v);
            rd_chk(6'h08, {29'h0, v[2:0]});
        end
        rd_chk(6'h20, 32'h00);
        wr(6'h0C, 8'hFE);
        rd_chk(6'h0C, 32'h01);
        @(posedge clk) ovr <= 1'b1;
        rd_chk(6'h0C, 32'h81);
        @(posedge clk) ovr <= 1'b0;
        rd_chk(6'h0C, 32'h01);
        wr(6'h10, 8'hFF);
        rd_chk(6'h10, 32'h9F);
        chk_reg({31'h0, cmd_irq}, 32'h1);
        rd_chk(6'h0C, 32'h01);
        arr(1'b0, 1'b0, 3);
        rd_chk(6'h1C, 32'h02);
        wr(6'h1C, 8'h03);
        wr(6'h10, 8'h0D);
        wr(6'h14, 8'h01);
        arr(1'b0, 1'b0, 3);
        rd_chk(6'h1C, 32'h01);
        chk_reg({31'h0, sgl_irq}, 32'h1);
        chk_reg({31'h0, cmd_irq}, 32'h0);
        wr(6'h1C, 8'h03);
        @(negedge clk);
        chk_reg({31'h0, sgl_irq}, 32'h0);
        for (int i = 1; i < 3; i++) begin
            wr(6'h10, 8'(i << 2));
            rd_chk(6'h10, 32'(i << 2));
            arr(1'b0, 1'b0, 4);
        end
        wr(6'h10, 8'h0C);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            arr(v[0], v[1], 3);
            rd_chk(6'h1C, {30'h0, v[1], v[0]});
            wr(6'h1C, 8'h03);
        end
        wr(6'h10, 8'h8C);
        wr(6'h18, 8'h80);
        @(negedge clk);
        chk_reg({31'h0, cmd_irq}, 32'h0);
        rd_chk(6'h18, 32'h08);
        wr(6'h10, 8'h80);
        rd_chk(6'h10, 32'h8C);
        wait_done;
        chk_reg({31'h0, cmd_irq}, 32'h1);
        wr(6'h18, 8'h80);
        @(posedge clk) viol <= 1'b1;
        @(posedge clk) viol <= 1'b0;
        rd_chk(6'h18, 32'h80);
        @(posedge clk) ers_req <= 1'b1;
        rd_chk(6'h10, 32'hAC);
        @(posedge clk) ers_req <= 1'b0;
        rd_chk(6'h18, 32'h08);
        wait_done;
        rd_chk(6'h10, 32'h8C);
        chk_reg({30'h0, sec}, {30'h0, SEC_UNSECURED});
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        @(negedge clk);
        chk_reg({30'h0, sec}, {30'h0, SEC_RESET});
        @(posedge clk) bkdr <= 1'b1;
        @(posedge clk) bkdr <= 1'b0;
        @(negedge clk);
        chk_reg({30'h0, sec}, {30'h0, SEC_UNSECURED});
        tally_and_finish;
    end

endmodule : fcsr_regs_tb
